// ---- core/ctm_cfg.svh ----
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// Register indices on the 8-bit Avalon bus
`define CTM_ADDR_CTRL0 3'h0
`define CTM_ADDR_CTRL1 3'h1
`define CTM_ADDR_CNT_LO 3'h2
`define CTM_ADDR_CNT_HI 3'h3
`define CTM_ADDR_CMP_LO 3'h4
`define CTM_ADDR_CMP_HI 3'h5
`define CTM_ADDR_PINCFG 3'h6

// timer_control_zero fields
`define CTM_C0_PAUSE 7
`define CTM_C0_CKS_HI 6
`define CTM_C0_CKS_LO 4
`define CTM_C0_ENABLE 3
`define CTM_C0_RP_HI 2
`define CTM_C0_RP_LO 0

// timer_control_one fields
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_IO_HI 5
`define CTM_C1_IO_LO 4
`define CTM_C1_OC 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0

// Pin configuration fields
`define CTM_PIN_INV_A 0
`define CTM_PIN_INV_B 1
`define CTM_PIN_EN_A 2
`define CTM_PIN_EN_B 3

// Reset and limit values
`define CTM_RST_BYTE 8'h00
`define CTM_RST_PIN 4'h0
`define CTM_RST_CMP 10'h000
`define CTM_RST_CNT 10'h000
`define CTM_RST_PRE 6'h00
`define CTM_ZERO_RP 3'h0
`define CTM_ZERO_LOW7 7'h00
`define CTM_HI_PAD 6'h00
`define CTM_PIN_PAD 4'h0
`define CTM_CNT_ONE 10'h001
`define CTM_PRE_ONE 6'h01
`define CTM_RST_BIT 1'b0

// Prescaler tap masks
`define CTM_PRE_DIV4 6'h03
`define CTM_PRE_DIV16 6'h0F
`define CTM_PRE_DIV64 6'h3F

`endif

// ---- core/ctm_pkg.sv ----
package ctm_pkg;

  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'b00,
    CTM_MODE_UNDEF = 2'b01,
    CTM_MODE_PWM = 2'b10,
    CTM_MODE_TMR = 2'b11
  } ctm_mode_e;

  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'b000,
    CTM_CK_SYS = 3'b001,
    CTM_CK_HI16 = 3'b010,
    CTM_CK_HI64 = 3'b011,
    CTM_CK_SUB = 3'b100,
    CTM_CK_RSVD = 3'b101,
    CTM_CK_EXTR = 3'b110,
    CTM_CK_EXTF = 3'b111
  } ctm_clksel_e;

  typedef enum logic [1:0] {
    CTM_IO_KEEP = 2'b00,
    CTM_IO_LOW = 2'b01,
    CTM_IO_HIGH = 2'b10,
    CTM_IO_TOGGLE = 2'b11
  } ctm_ioact_e;

  typedef struct packed {
    logic pinA;
    logic pinAEn;
    logic pinB;
    logic pinBEn;
  } ctm_pins_s;

  typedef struct packed {
    logic matchA;
    logic matchP;
  } ctm_events_s;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [3:0] pinCfg;
    logic [9:0] compareValue;
    logic [7:0] lowBuf;
    logic [9:0] count;
    logic outLevel;
    logic enPrev;
    logic [5:0] prescale;
    logic extMeta;
    logic extSync;
    logic extPrev;
    logic subMeta;
    logic subSync;
    logic subPrev;
    logic ack;
    logic [7:0] readData;
    ctm_pins_s pins;
    ctm_events_s events;
  } ctm_state_s;

endpackage

// ---- core/ctm_timer.sv ----
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`include "ctm_cfg.svh"

module ctm_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  // Asynchronous clock pins
  input wire logic externalClockInput,
  input wire logic subClock,
  // Timer outputs
  output ctm_pkg::ctm_pins_s timerPins,
  output ctm_pkg::ctm_events_s timerEvents,
  output logic [9:0] counterValue
);

  ctm_pkg::ctm_state_s s_q;
  ctm_pkg::ctm_state_s s_d;

  // Decoded control fields
  logic pauseBit;
  logic moduleEnableBit;
  logic [2:0] periodValueField;
  ctm_pkg::ctm_clksel_e clockSelectField;
  ctm_pkg::ctm_mode_e modeField;
  ctm_pkg::ctm_ioact_e outputActionField;
  logic outputControlBit;
  logic outputPolarityBit;
  logic periodDutySwapBit;
  logic counterClearSelectBit;

  // Working terms
  logic busReq;
  logic busDone;
  logic enRise;
  logic tick;
  logic run;
  logic [9:0] nextCount;
  logic hitA;
  logic hitP;
  logic clearByA;
  logic clearHit;
  logic pwmActive;
  logic [9:0] dutyValue;
  logic timerLevel;
  logic [7:0] readMux;
  logic tapDiv4;
  logic tapDiv16;
  logic tapDiv64;
  logic subRise;
  logic extRise;
  logic extFall;
  logic cmpMode;
  logic pwmMode;
  logic tmrMode;
  logic pinUsed;
  logic pinLevelA;
  logic pinLevelB;

  assign pauseBit = s_q.ctrl0[`CTM_C0_PAUSE];
  assign moduleEnableBit = s_q.ctrl0[`CTM_C0_ENABLE];
  assign periodValueField = s_q.ctrl0[`CTM_C0_RP_HI:`CTM_C0_RP_LO];
  assign clockSelectField =
    ctm_pkg::ctm_clksel_e'(s_q.ctrl0[`CTM_C0_CKS_HI:`CTM_C0_CKS_LO]);
  assign modeField =
    ctm_pkg::ctm_mode_e'(s_q.ctrl1[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
  assign outputActionField =
    ctm_pkg::ctm_ioact_e'(s_q.ctrl1[`CTM_C1_IO_HI:`CTM_C1_IO_LO]);
  assign outputControlBit = s_q.ctrl1[`CTM_C1_OC];
  assign outputPolarityBit = s_q.ctrl1[`CTM_C1_POL];
  assign periodDutySwapBit = s_q.ctrl1[`CTM_C1_DPX];
  assign counterClearSelectBit = s_q.ctrl1[`CTM_C1_CCLR];

  // One wait cycle lets read data come from a flop
  assign busReq = avs_read | avs_write;
  assign busDone = busReq & s_q.ack;
  assign avs_waitrequest = busReq & ~s_q.ack;
  assign avs_readdata = s_q.readData;
  assign timerPins = s_q.pins;
  assign timerEvents = s_q.events;
  assign counterValue = s_q.count;

  assign enRise = moduleEnableBit & ~s_q.enPrev;

  // Prescaler taps; all ones on the low bits marks one divided tick
  assign tapDiv4 = (s_q.prescale & `CTM_PRE_DIV4) == `CTM_PRE_DIV4;
  assign tapDiv16 = (s_q.prescale & `CTM_PRE_DIV16) == `CTM_PRE_DIV16;
  assign tapDiv64 = s_q.prescale == `CTM_PRE_DIV64;

  // Edges only from the second sync stage, never the first
  assign subRise = s_q.subSync & ~s_q.subPrev;
  assign extRise = s_q.extSync & ~s_q.extPrev;
  assign extFall = ~s_q.extSync & s_q.extPrev;

  // Mode decode; the undefined code acts like compare without pin action
  assign cmpMode = modeField == ctm_pkg::CTM_MODE_CMP;
  assign pwmMode = modeField == ctm_pkg::CTM_MODE_PWM;
  assign tmrMode = modeField == ctm_pkg::CTM_MODE_TMR;

  // Counter clock source
  always_comb begin
    case (clockSelectField)
      ctm_pkg::CTM_CK_SYS4: begin
        tick = tapDiv4;
      end
      ctm_pkg::CTM_CK_SYS: begin
        tick = 1'b1;
      end
      ctm_pkg::CTM_CK_HI16: begin
        // High clock equals system clock in this build
        tick = tapDiv16;
      end
      ctm_pkg::CTM_CK_HI64: begin
        tick = tapDiv64;
      end
      ctm_pkg::CTM_CK_SUB: begin
        tick = subRise;
      end
      ctm_pkg::CTM_CK_EXTR: begin
        tick = extRise;
      end
      ctm_pkg::CTM_CK_EXTF: begin
        tick = extFall;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // Counting and comparators
  // Enable edge beats a tick so the cleared count really starts at zero
  always_comb begin
    run = tick & moduleEnableBit & ~pauseBit & ~enRise;
    nextCount = s_q.count + `CTM_CNT_ONE;
    hitA = (s_q.compareValue != `CTM_RST_CMP)
      && (nextCount == s_q.compareValue);
    hitP = (periodValueField != `CTM_ZERO_RP)
      && (nextCount[9:7] == periodValueField)
      && (nextCount[6:0] == `CTM_ZERO_LOW7);
    if (pwmMode) begin
      clearByA = periodDutySwapBit;
    end else begin
      clearByA = counterClearSelectBit;
    end
    if (clearByA) begin
      clearHit = hitA;
    end else begin
      clearHit = hitP;
    end
    if (periodDutySwapBit) begin
      dutyValue = {periodValueField, `CTM_ZERO_LOW7};
    end else begin
      dutyValue = s_q.compareValue;
    end
    pwmActive = s_q.count < dutyValue;
  end

  // Pin level before polarity
  always_comb begin
    if (pwmMode) begin
      case (outputActionField)
        ctm_pkg::CTM_IO_KEEP: begin
          timerLevel = ~outputControlBit;
        end
        ctm_pkg::CTM_IO_LOW: begin
          timerLevel = outputControlBit;
        end
        ctm_pkg::CTM_IO_HIGH: begin
          timerLevel = pwmActive ? outputControlBit : ~outputControlBit;
        end
        default: begin
          timerLevel = s_q.outLevel;
        end
      endcase
    end else begin
      timerLevel = s_q.outLevel;
    end
  end

  // Per-pin levels; pins stay idle in timer mode
  assign pinUsed = ~tmrMode;
  assign pinLevelA = timerLevel ^ outputPolarityBit ^ s_q.pinCfg[`CTM_PIN_INV_A];
  assign pinLevelB = timerLevel ^ outputPolarityBit ^ s_q.pinCfg[`CTM_PIN_INV_B];

  // Read decode
  always_comb begin
    if (avs_address == `CTM_ADDR_CTRL0) begin
      readMux = s_q.ctrl0;
    end else if (avs_address == `CTM_ADDR_CTRL1) begin
      readMux = s_q.ctrl1;
    end else if (avs_address == `CTM_ADDR_CNT_LO) begin
      readMux = s_q.lowBuf;
    end else if (avs_address == `CTM_ADDR_CNT_HI) begin
      readMux = {`CTM_HI_PAD, s_q.count[9:8]};
    end else if (avs_address == `CTM_ADDR_CMP_LO) begin
      readMux = s_q.lowBuf;
    end else if (avs_address == `CTM_ADDR_CMP_HI) begin
      readMux = {`CTM_HI_PAD, s_q.compareValue[9:8]};
    end else if (avs_address == `CTM_ADDR_PINCFG) begin
      readMux = {`CTM_PIN_PAD, s_q.pinCfg};
    end else begin
      readMux = `CTM_RST_BYTE;
    end
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.ack = avs_waitrequest;
    s_d.events = '0;
    // Free-running prescaler; wraps so every tap stays periodic
    s_d.prescale = s_q.prescale + `CTM_PRE_ONE;
    s_d.extMeta = externalClockInput;
    s_d.extSync = s_q.extMeta;
    s_d.extPrev = s_q.extSync;
    s_d.subMeta = subClock;
    s_d.subSync = s_q.subMeta;
    s_d.subPrev = s_q.subSync;
    s_d.enPrev = moduleEnableBit;

    // Read data captured in the wait cycle
    if (avs_read && !s_q.ack) begin
      s_d.readData = readMux;
    end

    // Side effects land on the completing edge
    if (busDone && avs_write) begin
      if (avs_address == `CTM_ADDR_CTRL0) begin
        s_d.ctrl0 = avs_writedata;
      end else if (avs_address == `CTM_ADDR_CTRL1) begin
        s_d.ctrl1 = avs_writedata;
      end else if (avs_address == `CTM_ADDR_CMP_LO) begin
        s_d.lowBuf = avs_writedata;
      end else if (avs_address == `CTM_ADDR_CMP_HI) begin
        s_d.compareValue = {avs_writedata[1:0], s_q.lowBuf};
      end else if (avs_address == `CTM_ADDR_PINCFG) begin
        s_d.pinCfg = avs_writedata[3:0];
      end else if (avs_address == `CTM_ADDR_CNT_LO || avs_address == `CTM_ADDR_CNT_HI) begin
        // Counter bytes are read only; such writes fall away
        s_d.count = s_q.count;
      end
    end else if (busDone && avs_read) begin
      if (avs_address == `CTM_ADDR_CNT_HI) begin
        s_d.lowBuf = s_q.count[7:0];
      end else if (avs_address == `CTM_ADDR_CMP_HI) begin
        s_d.lowBuf = s_q.compareValue[7:0];
      end
    end

    // Counter: no software write path besides the enable edge
    if (enRise) begin
      s_d.count = `CTM_RST_CNT;
    end else if (run) begin
      if (clearHit) begin
        s_d.count = `CTM_RST_CNT;
      end else begin
        s_d.count = nextCount;
      end
    end
    // Enable low simply leaves count untouched

    // Match events, one pulse per counter clock
    s_d.events.matchA = run & hitA;
    s_d.events.matchP = run & hitP & ~clearByA;

    // Compare-mode output action
    if (enRise && cmpMode) begin
      s_d.outLevel = outputControlBit;
    end else if (run && hitA && cmpMode) begin
      case (outputActionField)
        ctm_pkg::CTM_IO_LOW: begin
          s_d.outLevel = 1'b0;
        end
        ctm_pkg::CTM_IO_HIGH: begin
          s_d.outLevel = 1'b1;
        end
        ctm_pkg::CTM_IO_TOGGLE: begin
          s_d.outLevel = ~s_q.outLevel;
        end
        default: begin
          s_d.outLevel = s_q.outLevel;
        end
      endcase
    end

    // Pins unused in timer mode; polarity inverts both
    s_d.pins.pinA = pinLevelA;
    s_d.pins.pinB = pinLevelB;
    s_d.pins.pinAEn = s_q.pinCfg[`CTM_PIN_EN_A] & pinUsed;
    s_d.pins.pinBEn = s_q.pinCfg[`CTM_PIN_EN_B] & pinUsed;
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
      s_q.ctrl0 <= `CTM_RST_BYTE;
      s_q.ctrl1 <= `CTM_RST_BYTE;
      s_q.pinCfg <= `CTM_RST_PIN;
      s_q.compareValue <= `CTM_RST_CMP;
      s_q.lowBuf <= `CTM_RST_BYTE;
      s_q.count <= `CTM_RST_CNT;
      s_q.prescale <= `CTM_RST_PRE;
      s_q.readData <= `CTM_RST_BYTE;
      s_q.outLevel <= `CTM_RST_BIT;
      s_q.enPrev <= `CTM_RST_BIT;
      s_q.extMeta <= `CTM_RST_BIT;
      s_q.extSync <= `CTM_RST_BIT;
      s_q.extPrev <= `CTM_RST_BIT;
      s_q.subMeta <= `CTM_RST_BIT;
      s_q.subSync <= `CTM_RST_BIT;
      s_q.subPrev <= `CTM_RST_BIT;
      s_q.ack <= `CTM_RST_BIT;
      s_q.pins <= '0;
      s_q.events <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ---- verif/ctm_timer_asserts.sv ----
`timescale 1ns/100ps
module ctm_timer_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bus
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Timer
  input wire ctm_pkg::ctm_events_s timerEvents,
  input wire logic [9:0] counterValue
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  wire req = avs_read | avs_write;
  wire hiRd = avs_read & ~avs_waitrequest & (avs_address == 3'h3 | avs_address == 3'h5);
  AST_ONE_WAIT: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  AST_IDLE: assert property (!req |-> !avs_waitrequest)
    else $error("wait without request");
  AST_HI_PAD: assert property (hiRd |-> avs_readdata[7:2] == 6'h00)
    else $error("high byte pad not zero");
  AST_CNT_HI: assert property (hiRd && avs_address == 3'h3 |->
    avs_readdata[1:0] == $past(counterValue[9:8])) else $error("counter high byte wrong");
  AST_STEP: assert property (counterValue != $past(counterValue) |->
    counterValue == $past(counterValue) + 10'h001 || counterValue == 10'h000)
    else $error("counter jumped");
  AST_A_PULSE: assert property (timerEvents.matchA |=> !timerEvents.matchA)
    else $error("match pulse too long");
  AST_P_CLR: assert property ($rose(timerEvents.matchP) |-> counterValue <= 10'h001)
    else $error("period match without clear");
  AST_RD_HOLD: assert property (!avs_read || !avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data moved");
  cover property (timerEvents.matchA);
  cover property (timerEvents.matchP);
  cover property (hiRd);
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic externalClockInput = 1'b0;
  logic subClock = 1'b0;
  logic [7:0] ph = 8'h00;
  ctm_pkg::ctm_pins_s timerPins;
  ctm_pkg::ctm_pins_s pv;
  ctm_pkg::ctm_events_s timerEvents;
  logic [9:0] counterValue;
  logic [9:0] v;
  logic [7:0] q;
  int n;
  int h;
  int errorCnt = 0;
  int checkCount = 0;

  always #4 clock = ~clock;
  // Sub clock 1/16, external pin 1/8 of system rate
  always @(posedge clock) begin
    ph <= ph + 8'h01;
    subClock <= ph[3];
    externalClockInput <= ph[2];
  end

  ctm_timer dut (.clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .externalClockInput, .subClock, .timerPins,
    .timerEvents, .counterValue);

  task automatic ck(input logic [9:0] g, input int e, input int t);
    checkCount++;
    if ($isunknown(g) || g > e + t || g + t < e) begin
      errorCnt++;
      $display("ERROR %0t got %h expected %0d", $time, g, e);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      errorCnt++;
      $display("ERROR %0t bus request never answered", $time);
    end
    @(posedge clock);
  endtask

  task automatic cw(input int k);
    repeat (k) @(negedge clock);
    v = counterValue;
    pv = timerPins;
    @(posedge clock);
  endtask

  task automatic ev(input logic s);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((s ? timerEvents.matchA : timerEvents.matchP) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      errorCnt++;
      $display("ERROR %0t match event never came", $time);
    end
    @(posedge clock);
  endtask

  task automatic tRegs;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 3'(i), 8'h00);
      ck({2'h0, q}, 0, 0);
    end
    bus(1'b1, 3'h3, 8'hFF);
    cw(1);
    ck(v, 0, 0);
    bus(1'b1, 3'h4, 8'hA5);
    bus(1'b1, 3'h5, 8'hFE);
    bus(1'b0, 3'h5, 8'h00);
    ck({2'h0, q}, 8'h02, 0);
    bus(1'b0, 3'h4, 8'h00);
    ck({2'h0, q}, 8'hA5, 0);
  endtask

  task automatic tRate;
    int e[8] = '{64, 256, 16, 4, 16, 0, 32, 32};
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 3'h0, 8'h00);
      bus(1'b1, 3'h0, 8'(c * 16 + 8));
      cw(256);
      ck(v, e[c], 3);
    end
  endtask

  task automatic tHold;
    bus(1'b1, 3'h0, 8'h18);
    cw(20);
    bus(1'b1, 3'h0, 8'h98);
    cw(1);
    h = v;
    cw(20);
    ck(v, h, 0);
    bus(1'b1, 3'h0, 8'h18);
    cw(20);
    ck(v, h + 21, 3);
    bus(1'b1, 3'h0, 8'h10);
    cw(1);
    h = v;
    cw(20);
    ck(v, h, 0);
    bus(1'b0, 3'h3, 8'h00);
    ck({2'h0, q}, h >> 8, 0);
    bus(1'b0, 3'h2, 8'h00);
    ck({2'h0, q}, h & 255, 0);
    bus(1'b1, 3'h0, 8'h18);
    cw(1);
    ck(v, 1, 2);
  endtask

  task automatic tPer;
    for (int p = 1; p < 8; p += 6) begin
      bus(1'b1, 3'h0, 8'h00);
      bus(1'b1, 3'h0, 8'(8'h18 + p));
      ev(1'b0);
      ev(1'b0);
      ck(10'(n), p * 128, 0);
    end
    bus(1'b1, 3'h0, 8'h00);
    bus(1'b1, 3'h0, 8'h18);
    n = 0;
    while (counterValue !== 10'h3FF && n < 1100) begin
      @(negedge clock);
      n++;
    end
    cw(1);
    ck(v, 0, 0);
    bus(1'b1, 3'h0, 8'h00);
    bus(1'b1, 3'h1, 8'h01);
    bus(1'b1, 3'h4, 8'h10);
    bus(1'b1, 3'h5, 8'h00);
    bus(1'b1, 3'h0, 8'h19);
    ev(1'b1);
    ev(1'b1);
    ck(10'(n), 16, 0);
  endtask

  // Entry: action field, initial level, level after a compare match
  task automatic tOut;
    logic [3:0] t[4] = '{4'b1110, 4'b0110, 4'b1001, 4'b0011};
    bus(1'b1, 3'h6, 8'h0E);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 3'h0, 8'h00);
      bus(1'b1, 3'h1, {2'b00, t[i][3:1], 3'b000});
      bus(1'b1, 3'h0, 8'h19);
      cw(2);
      ck(10'(pv.pinA), t[i][1], 0);
      ck(10'(pv.pinA ^ pv.pinB), 1, 0);
      ev(1'b1);
      cw(2);
      ck(10'(pv.pinA), t[i][0], 0);
    end
    ck(10'(pv.pinAEn), 1, 0);
    ck(10'(pv.pinBEn), 1, 0);
    bus(1'b1, 3'h0, 8'h00);
    bus(1'b1, 3'h1, 8'hC0);
    cw(2);
    ck(10'(pv.pinAEn), 0, 0);
    ck(10'(pv.pinBEn), 0, 0);
  endtask

  task automatic finalReport;
    $display("mismatches %0d comparisons %0d", errorCnt, checkCount);
    if (errorCnt == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    errorCnt++;
    finalReport();
  end

  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    tRegs();
    tRate();
    tHold();
    tPer();
    tOut();
    finalReport();
  end
endmodule

bind ctm_timer ctm_timer_asserts uChk (.clock, .reset, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .timerEvents, .counterValue);
